/* File: shared/bpc_pkg.sv */
/*
  Package of the binary position control block: timing counts, position
  limits, reset values and the carrier structs of the binary lines.
  Assumes a 125 MHz system clock; the core, master model and bench import this package.
*/
// Contract
// - direction level selects open or close stepping
// - each step pulse moves one increment
// - preset one input drives toward preset one
// - preset two input drives toward preset two
// - reset held 50 ms clears error, resets
// - qualified reset starts a reference run
// - error output only in automatic mode
// - error persists until acknowledged
// - reached flags: closed, open, preset one, two
// - offline whenever external lines are ignored
// - preset one wins over preset two
// - manual mode uses local buttons only
// - requests beyond end positions are discarded
`default_nettype none
package bpc_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned BPC_CLK_HZ = 125_000_000;
  localparam int unsigned BPC_RESET_MIN_MS = 50;
  localparam int unsigned BPC_RESET_MIN_CYC =
    (BPC_CLK_HZ / 1000) * BPC_RESET_MIN_MS;

  // ---------------------------------------------------------------
  // position range and reset values
  // ---------------------------------------------------------------
  localparam int unsigned BPC_POS_W = 16;
  localparam logic [15:0] BPC_POS_CLOSED = 16'h0000;
  localparam logic [15:0] BPC_POS_OPEN = 16'h0FA0;
  localparam logic [15:0] BPC_POS_RESET = 16'h0000;
  localparam int unsigned BPC_REF_CYC_DEF = 1000;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic dir_open;
    logic step;
    logic preset1;
    logic preset2;
    logic ext_reset;
  } bpc_cmd_t;

  typedef struct packed {
    logic error;
    logic closed;
    logic opened;
    logic at_preset1;
    logic at_preset2;
    logic offline;
  } bpc_stat_t;

  typedef enum logic [1:0] {
    BPC_ST_REF,
    BPC_ST_RUN,
    BPC_ST_ERR
  } bpc_state_t;

endpackage
`default_nettype wire

/* File: src/bpc_sync.sv */
/*
  Two flip-flop level synchroniser, one stage pair per bit.
  Assumes the inputs are levels from outside the clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module bpc_sync #(
  parameter int unsigned WIDTH = 5
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_reg;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      always_ff @(posedge clk_sys_in or posedge rst_in)
      begin
        if (rst_in)
        begin
          meta_reg[gi] <= 1'b0;
          q_out[gi] <= 1'b0;
        end
        else
        begin
          meta_reg[gi] <= d_in[gi];
          q_out[gi] <= meta_reg[gi];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* File: src/bpc_core.sv */
/*
  Binary position control: step/direction and preset commands from the
  master control, qualified external reset, reference run and the
  status outputs. Assumes preset positions and the fault condition come
  from elsewhere in the driver as steady levels on the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module bpc_core
  import bpc_pkg::*;
#(
  parameter int unsigned RESET_MIN_CYC = BPC_RESET_MIN_CYC,
  parameter int unsigned REF_CYC = BPC_REF_CYC_DEF
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire bpc_cmd_t cmd_in,
  input wire logic auto_mode_in,
  input wire logic btn_open_in,
  input wire logic btn_close_in,
  input wire logic fault_in,
  input wire logic ack_in,
  input wire logic [15:0] preset1_pos_in,
  input wire logic [15:0] preset2_pos_in,
  output bpc_stat_t stat_out,
  output logic [15:0] position_out
);

  // ---------------------------------------------------------------
  // input synchronisation
  // ---------------------------------------------------------------
  logic [7:0] raw_in;
  logic [7:0] sync_q;
  bpc_cmd_t cmd_s;
  logic auto_s;
  logic bopen_s;
  logic bclose_s;
  logic step_d_reg;
  logic step_rise;

  assign raw_in = {cmd_in, auto_mode_in, btn_open_in, btn_close_in};

  bpc_sync #(.WIDTH(8)) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .d_in(raw_in),
    .q_out(sync_q)
  );

  assign cmd_s = sync_q[7:3];
  assign auto_s = sync_q[2];
  assign bopen_s = sync_q[1];
  assign bclose_s = sync_q[0];

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      step_d_reg <= 1'b0;
    else
      step_d_reg <= cmd_s.step;
  end

  assign step_rise = cmd_s.step & ~step_d_reg;

  // ---------------------------------------------------------------
  // qualified external reset
  // ---------------------------------------------------------------
  logic [23:0] rst_cnt_reg;
  logic ext_rst_pulse;

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      rst_cnt_reg <= 24'h000000;
    else if (!cmd_s.ext_reset)
      rst_cnt_reg <= 24'h000000;
    else if (rst_cnt_reg < 24'(RESET_MIN_CYC))
      rst_cnt_reg <= rst_cnt_reg + 24'h000001;
  end

  // one pulse when the line has stood high long enough
  assign ext_rst_pulse = cmd_s.ext_reset &&
    (rst_cnt_reg == 24'(RESET_MIN_CYC - 1));

  // ---------------------------------------------------------------
  // state machine
  // ---------------------------------------------------------------
  bpc_state_t state_reg;
  logic [23:0] ref_cnt_reg;
  logic ref_done;

  assign ref_done = (ref_cnt_reg == 24'(REF_CYC - 1));

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      state_reg <= BPC_ST_REF;
    else if (ext_rst_pulse)
      state_reg <= BPC_ST_REF;
    else
    begin
      unique case (state_reg)
        BPC_ST_REF:
          if (ref_done)
            state_reg <= BPC_ST_RUN;
        BPC_ST_RUN:
          if (fault_in)
            state_reg <= BPC_ST_ERR;
        BPC_ST_ERR:
          if (ack_in)
            state_reg <= BPC_ST_RUN;
        default:
          state_reg <= BPC_ST_REF;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      ref_cnt_reg <= 24'h000000;
    else if (state_reg != BPC_ST_REF || ext_rst_pulse)
      ref_cnt_reg <= 24'h000000;
    else if (!ref_done)
      ref_cnt_reg <= ref_cnt_reg + 24'h000001;
  end

  // ---------------------------------------------------------------
  // position
  // ---------------------------------------------------------------
  logic [15:0] pos_reg;
  logic [15:0] target;
  logic preset_act;
  logic ext_ok;
  logic move_up;
  logic move_dn;

  // external step and preset lines are honoured only in automatic mode in the run state
  assign ext_ok = auto_s && (state_reg == BPC_ST_RUN);

  always_comb
  begin
    preset_act = 1'b0;
    target = pos_reg;
    move_up = 1'b0;
    move_dn = 1'b0;
    if (!auto_s)
    begin
      move_up = bopen_s & ~bclose_s;
      move_dn = bclose_s & ~bopen_s;
    end
    else if (ext_ok)
    begin
      if (cmd_s.preset1)
      begin
        preset_act = 1'b1;
        target = preset1_pos_in;
      end
      else if (cmd_s.preset2)
      begin
        preset_act = 1'b1;
        target = preset2_pos_in;
      end
      if (preset_act)
      begin
        move_up = target > pos_reg;
        move_dn = target < pos_reg;
      end
      else if (step_rise)
      begin
        move_up = cmd_s.dir_open;
        move_dn = ~cmd_s.dir_open;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      pos_reg <= BPC_POS_RESET;
    else if (state_reg == BPC_ST_REF)
      pos_reg <= BPC_POS_CLOSED;
    else if (move_up && pos_reg < BPC_POS_OPEN)
      pos_reg <= pos_reg + 16'h0001;
    else if (move_dn && pos_reg > BPC_POS_CLOSED)
      pos_reg <= pos_reg - 16'h0001;
  end

  // ---------------------------------------------------------------
  // status outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      stat_out <= '0;
      position_out <= BPC_POS_RESET;
    end
    else
    begin
      stat_out.error <= (state_reg == BPC_ST_ERR) && auto_s;
      stat_out.closed <= pos_reg == BPC_POS_CLOSED;
      stat_out.opened <= pos_reg == BPC_POS_OPEN;
      stat_out.at_preset1 <= pos_reg == preset1_pos_in;
      stat_out.at_preset2 <= pos_reg == preset2_pos_in;
      stat_out.offline <= !ext_ok;
      position_out <= pos_reg;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_step_up;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ext_ok && !cmd_s.preset1 && !cmd_s.preset2 && step_rise &&
     cmd_s.dir_open && pos_reg < BPC_POS_OPEN && !ext_rst_pulse)
    |=> pos_reg == $past(pos_reg) + 16'h0001;
  endproperty
  a_step_up: assert property (p_step_up)
    else $error("step toward open did not add one");

  property p_step_dn;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ext_ok && !cmd_s.preset1 && !cmd_s.preset2 && step_rise &&
     !cmd_s.dir_open && pos_reg > BPC_POS_CLOSED && !ext_rst_pulse)
    |=> pos_reg == $past(pos_reg) - 16'h0001;
  endproperty
  a_step_dn: assert property (p_step_dn)
    else $error("step toward closed did not subtract one");

  property p_preset1;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ext_ok && cmd_s.preset1 && preset1_pos_in > pos_reg &&
     pos_reg < BPC_POS_OPEN && !ext_rst_pulse) |=> pos_reg > $past(pos_reg);
  endproperty
  a_preset1: assert property (p_preset1)
    else $error("no move toward preset one");

  property p_preset2;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ext_ok && !cmd_s.preset1 && cmd_s.preset2 &&
     preset2_pos_in < pos_reg && !ext_rst_pulse) |=> pos_reg < $past(pos_reg);
  endproperty
  a_preset2: assert property (p_preset2)
    else $error("no move toward preset two");

  property p_prio;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ext_ok && cmd_s.preset1 && cmd_s.preset2 && !ext_rst_pulse &&
     preset1_pos_in == pos_reg) |=> pos_reg == $past(pos_reg);
  endproperty
  a_prio: assert property (p_prio)
    else $error("preset two overrode preset one");

  property p_ext_rst;
    @(posedge clk_sys_in) disable iff (rst_in)
    ext_rst_pulse |=> state_reg == BPC_ST_REF ##1 stat_out.offline;
  endproperty
  a_ext_rst: assert property (p_ext_rst)
    else $error("qualified reset did not start reference run");

  property p_short_rst;
    @(posedge clk_sys_in) disable iff (rst_in)
    (cmd_s.ext_reset && !$past(cmd_s.ext_reset)) |-> rst_cnt_reg == 24'h000000;
  endproperty
  a_short_rst: assert property (p_short_rst)
    else $error("reset accepted before minimum hold");

  property p_err_auto;
    @(posedge clk_sys_in) disable iff (rst_in)
    stat_out.error |-> $past(auto_s) && $past(state_reg) == BPC_ST_ERR;
  endproperty
  a_err_auto: assert property (p_err_auto)
    else $error("error shown outside automatic error state");

  property p_err_hold;
    @(posedge clk_sys_in) disable iff (rst_in)
    (state_reg == BPC_ST_ERR && !ack_in && !ext_rst_pulse)
    |=> state_reg == BPC_ST_ERR;
  endproperty
  a_err_hold: assert property (p_err_hold)
    else $error("error left without acknowledge");

  property p_limits;
    @(posedge clk_sys_in) disable iff (rst_in)
    pos_reg <= BPC_POS_OPEN;
  endproperty
  a_limits: assert property (p_limits)
    else $error("position beyond open end");

  property p_offline;
    @(posedge clk_sys_in) disable iff (rst_in)
    (state_reg != BPC_ST_RUN || !auto_s) |=> stat_out.offline;
  endproperty
  a_offline: assert property (p_offline)
    else $error("offline low while external lines are ignored");

  property p_ref_ignore;
    @(posedge clk_sys_in) disable iff (rst_in)
    (state_reg == BPC_ST_REF) |=> pos_reg == BPC_POS_CLOSED;
  endproperty
  a_ref_ignore: assert property (p_ref_ignore)
    else $error("position moved during reference run");

  property p_closed_flag;
    @(posedge clk_sys_in) disable iff (rst_in)
    (pos_reg == BPC_POS_CLOSED) |=> stat_out.closed;
  endproperty
  a_closed_flag: assert property (p_closed_flag)
    else $error("closed flag missing");

  c_step: cover property (@(posedge clk_sys_in) ext_ok && step_rise);
  c_err: cover property (@(posedge clk_sys_in) stat_out.error);
  c_ack: cover property (@(posedge clk_sys_in)
    state_reg == BPC_ST_ERR ##1 state_reg == BPC_ST_RUN);
  c_ext_rst: cover property (@(posedge clk_sys_in) ext_rst_pulse);

endmodule
`default_nettype wire

/* File: verif/bpc_master_model.sv */
/*
  Master control model: drives the binary command lines of the core.
  Assumes one bench process calls its tasks, just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module bpc_master_model
  import bpc_pkg::*;
(
  input wire logic clk_sys_in,
  output var bpc_cmd_t cmd_out
);
  // ---------------------------------------------------------------
  // command tasks
  // ---------------------------------------------------------------
  initial cmd_out = '0;

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  // two low cycles after each high keep synced pulses apart
  task automatic step(input logic dir, input int n);
    cmd_out.dir_open = dir;
    tick(2);
    repeat (n)
    begin
      cmd_out.step = 1'b1;
      tick(2);
      cmd_out.step = 1'b0;
      tick(2);
    end
  endtask

  task automatic presets(input logic p1, input logic p2);
    cmd_out.preset1 = p1;
    cmd_out.preset2 = p2;
  endtask

  task automatic rst_line(input logic v);
    cmd_out.ext_reset = v;
  endtask
endmodule
`default_nettype wire

/* File: verif/binary_io_position_control_bench.sv */
/*
  Bench of the binary position control core: command and button calls
  with expected status and position.
  Assumes the core is built with short reset and reference counts.
*/
`timescale 1ns/1ps
`default_nettype none
module binary_io_position_control_bench
  import bpc_pkg::*;
;
  localparam int unsigned RST_CYC = 20;
  localparam int unsigned REF_CYC = 8;
  logic clk_sys_in;
  logic rst_in;
  logic auto_in;
  logic bo;
  logic bc;
  logic fault;
  logic ack;
  logic [15:0] p1;
  logic [15:0] p2;
  bpc_cmd_t cmd;
  bpc_stat_t stat;
  logic [15:0] pos;
  int err_count;
  int checked;

  bpc_master_model master_u (.clk_sys_in(clk_sys_in), .cmd_out(cmd));
  bpc_core #(.RESET_MIN_CYC(RST_CYC), .REF_CYC(REF_CYC)) dut_u (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .cmd_in(cmd),
    .auto_mode_in(auto_in), .btn_open_in(bo), .btn_close_in(bc),
    .fault_in(fault), .ack_in(ack), .preset1_pos_in(p1),
    .preset2_pos_in(p2), .stat_out(stat), .position_out(pos));

  initial
  begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic complete_run;
    if (err_count == 0 && checked > 0)
    begin
      $display("Finished cleanly");
    end
    else
    begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic ok);
    checked++;
    if (!ok)
    begin
      err_count++;
      $display("MISMATCH %0t check %0d failed", $time, checked);
    end
  endtask

  // sel 0 waits on position, sel 1 on the offline flag
  task automatic wait_on(input int sel, input logic [15:0] v, input int lim);
    int i;
    for (i = 0; i < lim; i++)
    begin
      if (sel == 0 ? pos === v : stat.offline === v[0])
        return;
      tick(1);
    end
    err_count++;
    $display("MISMATCH %0t wait ran out", $time);
    complete_run();
  endtask

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial
  begin
    err_count = 0;
    checked = 0;
    rst_in = 1'b1;
    auto_in = 1'b1;
    bo = 1'b0;
    bc = 1'b0;
    fault = 1'b0;
    ack = 1'b0;
    p1 = 16'h0010;
    p2 = 16'h0020;
    tick(6);
    rst_in = 1'b0;
    tick(2);
    chk(stat.offline === 1'b1);
    wait_on(1, 16'h0000, 40);
    chk(stat.closed === 1'b1 && pos === 16'h0000);
    master_u.step(1'b1, 3);
    tick(4);
    chk(pos === 16'h0003 && stat.closed === 1'b0);
    master_u.step(1'b0, 1);
    tick(4);
    chk(pos === 16'h0002);
    master_u.step(1'b0, 3);
    tick(4);
    chk(pos === 16'h0000 && stat.closed === 1'b1);
    master_u.presets(1'b0, 1'b1);
    wait_on(0, 16'h0020, 100);
    tick(2);
    chk(stat.at_preset2 === 1'b1);
    master_u.presets(1'b1, 1'b1);
    wait_on(0, 16'h0010, 100);
    tick(2);
    chk(stat.at_preset1 === 1'b1 && pos === 16'h0010);
    master_u.presets(1'b0, 1'b0);
    auto_in = 1'b0;
    tick(4);
    chk(stat.offline === 1'b1);
    master_u.step(1'b1, 2);
    tick(4);
    chk(pos === 16'h0010);
    bo = 1'b1;
    tick(6);
    bo = 1'b0;
    tick(4);
    chk(pos === 16'h0016);
    bo = 1'b1;
    bc = 1'b1;
    tick(6);
    bo = 1'b0;
    bc = 1'b0;
    tick(4);
    chk(pos === 16'h0016);
    bc = 1'b1;
    tick(4);
    bc = 1'b0;
    tick(4);
    chk(pos === 16'h0012);
    auto_in = 1'b1;
    p1 = 16'h0FA0;
    master_u.presets(1'b1, 1'b0);
    wait_on(0, 16'h0FA0, 5000);
    master_u.presets(1'b0, 1'b0);
    master_u.step(1'b1, 2);
    tick(4);
    chk(pos === 16'h0FA0 && stat.opened === 1'b1);
    p1 = 16'h0010;
    master_u.presets(1'b1, 1'b0);
    wait_on(0, 16'h0010, 5000);
    master_u.presets(1'b0, 1'b0);
    auto_in = 1'b0;
    fault = 1'b1;
    tick(5);
    chk(stat.error === 1'b0);
    auto_in = 1'b1;
    tick(4);
    chk(stat.error === 1'b1);
    chk(stat.offline === 1'b1);
    fault = 1'b0;
    tick(5);
    chk(stat.error === 1'b1);
    ack = 1'b1;
    tick(3);
    ack = 1'b0;
    tick(4);
    chk(stat.error === 1'b0);
    fault = 1'b1;
    tick(4);
    fault = 1'b0;
    master_u.rst_line(1'b1);
    tick(RST_CYC / 2);
    master_u.rst_line(1'b0);
    tick(30);
    chk(stat.error === 1'b1 && pos === 16'h0010);
    master_u.rst_line(1'b1);
    wait_on(0, 16'h0000, 60);
    chk(stat.offline === 1'b1 && stat.error === 1'b0);
    master_u.rst_line(1'b0);
    master_u.step(1'b1, 1);
    wait_on(1, 16'h0000, 40);
    chk(pos === 16'h0000);
    complete_run();
  end
endmodule
`default_nettype wire
